//--- src/mcdr_pkg.sv
// Constants and carrier types for the missing-clock detect and reset block.
// Assumes a single 125 MHz system clock; the crystal input is sampled on it.
package mcdr_pkg;

   // System clock period in picoseconds (125 MHz)
   localparam int unsigned CLK_PERIOD_PS   = 8000;

   // Internal fallback oscillator rate the clock mux switches to
   localparam int unsigned INTERNAL_OSCILLATOR_FREQ_MHZ = 10;

   // Longest crystal edge gap tolerated before the clock is judged missing
   localparam int unsigned MISS_TIME_NS    = 1000;
   // Least time rounds up to whole cycles
   localparam int unsigned MISS_CYCLES_INT =
      (MISS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned GAP_W           = 8;
   localparam logic [GAP_W-1:0] MISS_CYCLES = GAP_W'(MISS_CYCLES_INT);

   // Reset stretch length, in crystal clock cycles
   localparam int unsigned STRETCH_W       = 10;
   localparam logic [STRETCH_W-1:0] STRETCH_EDGES = 10'h200;

   // Non-maskable watchdog timeout, system clock cycles (default value)
   localparam int unsigned NONMASKABLE_WATCHDOG_W         = 16;
   localparam int unsigned NONMASKABLE_WATCHDOG_CYCLES    = 65535;

   // Reset values
   localparam logic [GAP_W-1:0]     GAP_RST     = 8'h00;
   localparam logic [STRETCH_W-1:0] STRETCH_RST = 10'h000;
   localparam logic [NONMASKABLE_WATCHDOG_W-1:0]   NONMASKABLE_WATCHDOG_RST   = 16'h0000;

   // Reset requests from the general-purpose watchdogs
   typedef struct packed {
      logic generalWatchdogZero;
      logic generalWatchdogOne;
   } mcdr_wdreq_t;

   // Status seen by the rest of the device
   typedef struct packed {
      logic missingClockFlag;   // sticky, cleared only by sys_rst
      logic clockFailBit;       // non-maskable event flag
      logic useInternalOsc;     // clock mux select
      logic deviceReset;        // stretched reset in progress
   } mcdr_status_t;

endpackage : mcdr_pkg

//--- src/mcdr_stretch.sv
// Reset stretcher counting crystal clock edges.
// Assumes crystalEdge is a one-cycle pulse per crystal rising edge.
`timescale 1ns/100ps

module mcdr_stretch (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   input  wire logic trigger,
   input  wire logic crystalEdge,
   output logic      active
);

   typedef struct packed {
      logic                               active;
      logic [mcdr_pkg::STRETCH_W-1:0]     count;
   } mcdr_stretch_state_t;

   mcdr_stretch_state_t state_q;
   mcdr_stretch_state_t state_d;

   always_comb begin
      state_d = state_q;
      if (trigger) begin
         // A new request restarts the full stretch
         state_d.active = 1'b1;
         state_d.count  = mcdr_pkg::STRETCH_RST;
      end else if (state_q.active && crystalEdge) begin
         // No crystal edges means the count never advances: reset persists
         if (state_q.count == mcdr_pkg::STRETCH_EDGES - 10'h001) begin
            state_d.active = 1'b0;
            state_d.count  = mcdr_pkg::STRETCH_RST;
         end else begin
            state_d.count = state_q.count + 10'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q.active <= 1'b0;
         state_q.count  <= mcdr_pkg::STRETCH_RST;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   assign active = state_q.active;

endmodule : mcdr_stretch

//--- src/mcdr_top.sv
// Missing crystal clock detection, clock fallback, clock-fail event,
// non-maskable watchdog and crystal-timed reset stretching.
// Assumes the crystal input is sampled as a synchronous level on clk and
// that software acknowledges the clock-fail event by a clear pulse.
// Assumes the crystal runs slower than half the clk rate, else edges are
// lost and a running crystal can be judged missing.
// Holding ce low freezes detection, the event timer and the stretch alike.
`timescale 1ns/100ps

module mcdr_top #(
   parameter int unsigned NONMASKABLE_WATCHDOG_TIMEOUT = mcdr_pkg::NONMASKABLE_WATCHDOG_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  ce,
   input  wire logic                  crystalClockInput,
   input  wire logic                  clockFailClear,
   input  wire mcdr_pkg::mcdr_wdreq_t watchdogReq,
   output mcdr_pkg::mcdr_status_t     status,
   output logic                       nonmaskableReq,
   output logic                       externalResetOut,
   output logic                       externalResetOeN
);

   typedef enum logic [0:0] {
      CRYSTAL_RUN,
      INTERNAL_RUN
   } mcdr_mode_t;

   typedef struct packed {
      mcdr_mode_t                      mode;
      logic                            crystalPrev;
      logic [mcdr_pkg::GAP_W-1:0]      gapCount;
      logic                            missingClockFlag;
      logic                            clockFailBit;
      logic [mcdr_pkg::NONMASKABLE_WATCHDOG_W-1:0]    nmiCount;
      logic                            nmiExpire;
   } mcdr_state_t;

   localparam logic [mcdr_pkg::NONMASKABLE_WATCHDOG_W-1:0] NMI_LAST =
      mcdr_pkg::NONMASKABLE_WATCHDOG_W'(NONMASKABLE_WATCHDOG_TIMEOUT - 1);

   // Next gap count; a crystal rising edge restarts the measure
   function automatic logic [mcdr_pkg::GAP_W-1:0] gap_next(
      input logic                       sawEdge,
      input logic [mcdr_pkg::GAP_W-1:0] count
   );
      logic [mcdr_pkg::GAP_W-1:0] result;
      if (sawEdge) begin
         result = mcdr_pkg::GAP_RST;
      end else begin
         result = count + 8'h01;
      end
      return result;
   endfunction : gap_next

   // Gap reached the miss limit with no crystal edge in this cycle
   function automatic logic gap_expired(
      input logic                       sawEdge,
      input logic [mcdr_pkg::GAP_W-1:0] count
   );
      logic expired;
      expired = !sawEdge && (count == mcdr_pkg::MISS_CYCLES);
      return expired;
   endfunction : gap_expired

   // Last count of the non-maskable watchdog; decides both the expire
   // pulse and the wrap, so the two cannot drift apart
   function automatic logic nmi_due(
      input logic [mcdr_pkg::NONMASKABLE_WATCHDOG_W-1:0] count
   );
      logic due;
      due = (count == NMI_LAST);
      return due;
   endfunction : nmi_due

   // Wrap restarts the count, so an unanswered event keeps firing
   function automatic logic [mcdr_pkg::NONMASKABLE_WATCHDOG_W-1:0] nmi_next(
      input logic [mcdr_pkg::NONMASKABLE_WATCHDOG_W-1:0] count
   );
      logic [mcdr_pkg::NONMASKABLE_WATCHDOG_W-1:0] result;
      if (nmi_due(count)) begin
         result = mcdr_pkg::NONMASKABLE_WATCHDOG_RST;
      end else begin
         result = count + 16'h0001;
      end
      return result;
   endfunction : nmi_next

   // Set wins: a clear in the cycle the bit is raised is dropped, so a
   // stale software clear can never hide a fresh clock failure
   function automatic logic clear_wins(
      input logic clearReq,
      input logic bitNow,
      input logic bitNext
   );
      logic wins;
      wins = clearReq && !(bitNext && !bitNow);
      return wins;
   endfunction : clear_wins

   // Any watchdog source asks for the same stretched reset
   function automatic logic reset_wanted(
      input mcdr_pkg::mcdr_wdreq_t req,
      input logic                  nmiFired
   );
      logic wanted;
      wanted = req.generalWatchdogZero
            || req.generalWatchdogOne
            || nmiFired;
      return wanted;
   endfunction : reset_wanted

   // Fallback select holds until a full reset
   function automatic logic in_fallback(
      input mcdr_mode_t mode
   );
      logic onInternal;
      onInternal = (mode == INTERNAL_RUN);
      return onInternal;
   endfunction : in_fallback

   mcdr_state_t state_q;
   mcdr_state_t state_d;
   logic        crystalEdge;
   logic        stretchTrigger;
   logic        stretchActive;

   assign crystalEdge = crystalClockInput && !state_q.crystalPrev;

   // Every watchdog source shares the crystal-timed stretch
   assign stretchTrigger = reset_wanted(watchdogReq,
                                        state_q.nmiExpire);

   always_comb begin
      state_d             = state_q;
      state_d.crystalPrev = crystalClockInput;
      state_d.nmiExpire   = 1'b0;

      case (state_q.mode)
         CRYSTAL_RUN: begin
            if (gap_expired(crystalEdge, state_q.gapCount)) begin
               // Also fires after reset if the crystal starts slowly
               state_d.mode             = INTERNAL_RUN;
               state_d.missingClockFlag = 1'b1;
               state_d.clockFailBit     = 1'b1;
               state_d.nmiCount         = mcdr_pkg::NONMASKABLE_WATCHDOG_RST;
            end else begin
               state_d.gapCount = gap_next(crystalEdge, state_q.gapCount);
            end
         end
         INTERNAL_RUN: begin
            // Fallback holds until a full reset; a returning crystal is
            // not trusted again without software re-initialising
            state_d.gapCount = mcdr_pkg::GAP_RST;
         end
         default: begin
            state_d.mode = CRYSTAL_RUN;
         end
      endcase

      // Clear loses to a detection in the same cycle
      if (clear_wins(clockFailClear, state_q.clockFailBit,
                     state_d.clockFailBit)) begin
         state_d.clockFailBit = 1'b0;
         state_d.nmiCount     = mcdr_pkg::NONMASKABLE_WATCHDOG_RST;
      end else if (state_q.clockFailBit) begin
         // Timer runs only while the event stands unanswered; its
         // reset request is stretched on the absent crystal
         state_d.nmiExpire = nmi_due(state_q.nmiCount);
         state_d.nmiCount  = nmi_next(state_q.nmiCount);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q.mode             <= CRYSTAL_RUN;
         // Keeps tracking, so a crystal stuck high shows no edge at release
         state_q.crystalPrev      <= crystalClockInput;
         state_q.gapCount         <= mcdr_pkg::GAP_RST;
         state_q.missingClockFlag <= 1'b0;
         state_q.clockFailBit     <= 1'b0;
         state_q.nmiCount         <= mcdr_pkg::NONMASKABLE_WATCHDOG_RST;
         state_q.nmiExpire        <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   mcdr_stretch u_stretch (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .ce          (ce),
      .trigger     (stretchTrigger),
      .crystalEdge (crystalEdge),
      .active      (stretchActive)
   );

   assign status.missingClockFlag = state_q.missingClockFlag;
   assign status.clockFailBit     = state_q.clockFailBit;
   assign status.useInternalOsc   = in_fallback(state_q.mode);
   assign status.deviceReset      = stretchActive;

   assign nonmaskableReq = state_q.clockFailBit;

   // Open-drain reset pin: pulled low only while stretching
   assign externalResetOut = 1'b0;
   assign externalResetOeN = !stretchActive;

endmodule : mcdr_top

//--- tb/mcdr_xtal_model.sv
// Crystal oscillator model for the clock input of mcdr_top.
// Assumes the bench starts and stops it through run.
`timescale 1ns/100ps
module mcdr_xtal_model (
   input  wire logic run,
   output logic      crystalClockInput
);
   // Offset keeps toggles off both clk edges; a dead crystal stands still
   initial begin
      crystalClockInput = 1'b0;
      #1;
      forever #20 if (run) crystalClockInput = ~crystalClockInput;
   end
endmodule : mcdr_xtal_model

//--- tb/mcdr_checker.sv
// Assertions for the missing-clock detect and reset block.
// Sees only the ports of mcdr_top; bound in below.
`timescale 1ns/100ps
module mcdr_checker #(parameter int unsigned NONMASKABLE_WATCHDOG_TIMEOUT = 20) (
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire logic                   ce,
   input wire logic                   crystalClockInput,
   input wire logic                   clockFailClear,
   input wire mcdr_pkg::mcdr_wdreq_t  watchdogReq,
   input wire mcdr_pkg::mcdr_status_t status,
   input wire logic                   nonmaskableReq,
   input wire logic                   externalResetOut,
   input wire logic                   externalResetOeN
);
   logic xPrev;
   int   gapCnt, edgeCnt, nmiCnt;
   wire  xRise = crystalClockInput && !xPrev;
   // Edge count clears on watchdogReq but grows past timer restarts, so it bounds the real stretch
   always_ff @(posedge clk) if (ce) begin
      xPrev   <= crystalClockInput;
      gapCnt  <= (sys_rst || xRise) ? 0 : gapCnt + 1;
      edgeCnt <= (sys_rst || |watchdogReq) ? 0 : edgeCnt + int'(xRise);
      nmiCnt  <= status.clockFailBit ? nmiCnt + 1 : 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_flag_sticky: assert property (status.missingClockFlag
      |=> status.missingClockFlag) else $error("Flag dropped");
   a_osc_select: assert property (
      status.useInternalOsc == status.missingClockFlag) else $error("Mux");
   a_detect_time: assert property (gapCnt == 130
      |-> status.missingClockFlag) else $error("Late detect");
   a_event_raise: assert property ($rose(status.missingClockFlag)
      |-> status.clockFailBit && nonmaskableReq) else $error("No event");
   a_clear_bit: assert property (ce && clockFailClear && nonmaskableReq
      |=> !status.clockFailBit && !nonmaskableReq) else $error("Kept");
   a_wd_stretch: assert property (ce && |watchdogReq
      |=> status.deviceReset) else $error("No stretch");
   a_pin_drive: assert property (
      externalResetOeN == !status.deviceReset && !externalResetOut)
      else $error("Pin");
   a_stretch_len: assert property ($fell(status.deviceReset)
      |-> edgeCnt >= 512) else $error("Short stretch");
   a_nmi_expire: assert property (nmiCnt == NONMASKABLE_WATCHDOG_TIMEOUT + 3
      |-> status.deviceReset) else $error("No watchdog reset");
   c_detect: cover property ($rose(status.missingClockFlag));
   c_release: cover property ($fell(status.deviceReset));
   c_clear: cover property ($fell(status.clockFailBit));
endmodule : mcdr_checker
bind mcdr_top mcdr_checker #(.NONMASKABLE_WATCHDOG_TIMEOUT(NONMASKABLE_WATCHDOG_TIMEOUT)) mcdr_checker_i (
   .clk(clk), .sys_rst(sys_rst), .ce(ce), .clockFailClear(clockFailClear),
   .crystalClockInput(crystalClockInput), .watchdogReq(watchdogReq),
   .status(status), .nonmaskableReq(nonmaskableReq),
   .externalResetOut(externalResetOut), .externalResetOeN(externalResetOeN));

//--- tb/mcdr_top_bench.sv
// Self-checking bench for mcdr_top with the crystal model.
// Inputs change on falling clk; watchdog timeout shortened to 20.
`timescale 1ns/100ps
module mcdr_top_bench;
   logic                   clk = 1'b0, sys_rst = 1'b1, run = 1'b1, ce = 1'b1;
   logic                   clockFailClear = 1'b0, crystalClockInput;
   logic                   nonmaskableReq, externalResetOut, externalResetOeN;
   mcdr_pkg::mcdr_wdreq_t  watchdogReq = '0;
   mcdr_pkg::mcdr_status_t status;
   int                     n_errors = 0, num_checks = 0, cyc = 0;
   mcdr_xtal_model mcdr_xtal_model_i (.run(run),
      .crystalClockInput(crystalClockInput));
   mcdr_top #(.NONMASKABLE_WATCHDOG_TIMEOUT(20)) mcdr_top_i (.clk(clk), .sys_rst(sys_rst),
      .ce(ce), .crystalClockInput(crystalClockInput), .status(status),
      .clockFailClear(clockFailClear), .watchdogReq(watchdogReq),
      .nonmaskableReq(nonmaskableReq), .externalResetOut(externalResetOut),
      .externalResetOeN(externalResetOeN));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(string what, logic [3:0] seen, logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic test_stretch();
      for (int w = 0; w < 2; w++) begin
         watchdogReq = w ? 2'b01 : 2'b10;
         tick(1);
         watchdogReq = '0;
         tick(1);
         chk("pin", {externalResetOut, externalResetOeN}, 4'h0);
         tick(2450);
         chk("deviceReset", status.deviceReset, 4'h1);
         for (int i = 0; i < 400 && status.deviceReset !== 1'b0; i++) tick(1);
         chk("resetOeN", externalResetOeN, 4'h1);
      end
      $display("Test stretch done");
   endtask : test_stretch
   task automatic test_detect();
      run = 1'b0;
      ce = 1'b0;
      tick(200);
      chk("frozen", status, 4'h0);
      ce = 1'b1;
      tick(118);
      chk("status", status, 4'h0);
      for (int i = 0; i < 20 && status.missingClockFlag !== 1'b1; i++) tick(1);
      chk("status", status, 4'hE);
      chk("nmiReq", nonmaskableReq, 4'h1);
      clockFailClear = 1'b1;
      tick(1);
      clockFailClear = 1'b0;
      tick(1);
      chk("status", status, 4'hA);
      watchdogReq = 2'b10;
      tick(1);
      watchdogReq = '0;
      tick(60);
      chk("status", status, 4'hB);
      run = 1'b1;
      tick(60);
      chk("status", status, 4'hB);
      for (int i = 0; i < 2700 && status.deviceReset !== 1'b0; i++) tick(1);
      chk("status", status, 4'hA);
      $display("Test detect done");
   endtask : test_detect
   task automatic test_nmi();
      sys_rst = 1'b1;
      tick(6);
      sys_rst = 1'b0;
      run = 1'b0;
      tick(174);
      chk("deviceReset", status.deviceReset, 4'h1);
      chk("flag", status.missingClockFlag, 4'h1);
      tick(600);
      chk("resetOeN", externalResetOeN, 4'h0);
      $display("Test nmi done");
   endtask : test_nmi
   task automatic results();
      $display("Checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      tick(6);
      sys_rst = 1'b0;
      test_stretch();
      test_detect();
      test_nmi();
      results();
   end
endmodule : mcdr_top_bench
